/* verilog/plcr_regs.sv */
// How it works
// R1 - LED override bits 15:6 ignore writes and read zero.
// R2 - Override bit 5 forces speed lamp to bit 2 value.
// R3 - Override bit 4 forces link lamp to bit 1 value.
// R4 - Override bit 3 forces activity/collision lamp to bit 0 value.
// R5 - Reading LED override returns stored controls, never the lamp pins.
// R6 - Software clears auto crossover whenever autonegotiation is off.
// R7 - Bit 14 forces crossed pairs; clear means normal pairs.
// R8 - Read-only bit 13: pause receive resolved, only when full duplex.
// R9 - Read-only bit 12: pause transmit resolved, only when full duplex.
// R10 - Writing one to bit 11 injects one self-test error, then clears.
// R11 - Bit 8 runs self-test; bit 9 latches pass, cleared on stop.
// R12 - Bit 7 bypasses lamp stretching so lamps show raw signals.
// R13 - Bit 10 selects the 15-stage sequence, else the 9-stage one.
// R14 - Mode field picks lamp display mode; speed lamp on at 100.
//
// Chosen here: register access over Avalon-MM.
`default_nettype none
module plcr_regs import plcr_pkg::*; (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Straps
	input wire logic strap_auto_crossover_i,
	input wire logic strap_lamp_mode0_i,
	input wire logic [4:0] strap_port_addr_i,
	// Negotiation results
	input wire logic [1:0] local_pause_i,
	input wire logic [1:0] partner_pause_i,
	input wire logic full_duplex_i,
	// Self-test engine
	input wire logic selftest_error_i,
	output logic selftest_run_o,
	output logic selftest_long_sequence_sel_o,
	output logic selftest_inject_error_o,
	// Crossover and address
	output logic auto_crossover_enable_o,
	output logic forced_crossover_o,
	output logic [4:0] port_management_address_o,
	// Lamp sources
	input wire logic link_good_i,
	input wire logic speed100_i,
	input wire logic blink_i,
	input wire logic activity_raw_i,
	input wire logic activity_stretched_i,
	input wire logic collision_raw_i,
	input wire logic collision_stretched_i,
	// Lamps
	output logic speed_lamp_out_o,
	output logic link_lamp_out_o,
	output logic activity_collision_lamp_out_o,
	// Interrupt
	output logic irq_o
);
	plcr_bus_e st_q, st_d;
	logic [31:0] rdata_q, rdata_d;
	logic [5:0] idx;
	logic wr_go;
	logic [15:0] wdat;
	logic [1:0] wlane;

	logic [PLCR_LED_W-1:0] led_q, led_d;
	logic autox_q, autox_d;
	logic forcex_q, forcex_d;
	logic prx_q, prx_d;
	logic ptx_q, ptx_d;
	logic inj_q, inj_d;
	logic long_q, long_d;
	logic pass_q, pass_d;
	logic run_q, run_d;
	logic byp_q, byp_d;
	logic [1:0] mode_q, mode_d;
	logic [4:0] addr_q, addr_d;
	logic strap_q, strap_d;
	logic [PLCR_IRQ_W-1:0] ists_q, ists_d;
	logic [PLCR_IRQ_W-1:0] imsk_q, imsk_d;
	logic [PLCR_IRQ_W-1:0] iev;
	logic [15:0] phy_rd;
	logic [2:0] lamps;

	assign idx = avs_address_i[7:2];
	assign wdat = avs_writedata_i[15:0];
	assign wlane = avs_byteenable_i[1:0];

	// ==========================================
	// Bus handshake: one wait cycle, then answer
	always_comb begin
		st_d = st_q;
		rdata_d = rdata_q;
		case (st_q)
			PLCR_ST_IDLE: begin
				if (avs_read_i || avs_write_i) begin
					st_d = PLCR_ST_ACK;
				end
				rdata_d = 32'h0;
				case (idx)
					PLCR_IDX_LED: rdata_d[PLCR_LED_W-1:0] = led_q; // R1 R5
					PLCR_IDX_PHY: rdata_d[15:0] = phy_rd;
					PLCR_IDX_IRQ_STAT: rdata_d[PLCR_IRQ_W-1:0] = ists_q;
					PLCR_IDX_IRQ_MASK: rdata_d[PLCR_IRQ_W-1:0] = imsk_q;
					default: rdata_d = 32'h0;
				endcase
			end
			PLCR_ST_ACK: st_d = PLCR_ST_IDLE;
			default: st_d = PLCR_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			st_q <= PLCR_ST_IDLE;
			rdata_q <= 32'h0;
		end else begin
			st_q <= st_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && st_q != PLCR_ST_ACK;
	assign avs_readdata_o = rdata_q;
	assign wr_go = avs_write_i && st_q == PLCR_ST_ACK;

	always_comb begin
		phy_rd = 16'h0;
		phy_rd[PLCR_PHY_AUTOX] = autox_q;
		phy_rd[PLCR_PHY_FORCEX] = forcex_q;
		phy_rd[PLCR_PHY_PRX] = prx_q;
		phy_rd[PLCR_PHY_PTX] = ptx_q;
		phy_rd[PLCR_PHY_INJ] = inj_q;
		phy_rd[PLCR_PHY_LONG] = long_q;
		phy_rd[PLCR_PHY_PASS] = pass_q;
		phy_rd[PLCR_PHY_RUN] = run_q;
		phy_rd[PLCR_PHY_BYP] = byp_q;
		phy_rd[PLCR_PHY_MODE_LSB+:2] = mode_q;
		phy_rd[PLCR_PHY_ADDR_LSB+:5] = addr_q;
	end

	// ==========================================
	// Control registers
	always_comb begin
		led_d = led_q;
		autox_d = autox_q;
		forcex_d = forcex_q;
		long_d = long_q;
		run_d = run_q;
		byp_d = byp_q;
		mode_d = mode_q;
		addr_d = addr_q;
		inj_d = 1'b0; // R10
		strap_d = 1'b0;
		if (strap_q) begin
			autox_d = strap_auto_crossover_i;
			mode_d[0] = strap_lamp_mode0_i;
			addr_d = strap_port_addr_i;
		end
		if (wr_go && idx == PLCR_IDX_LED && wlane[0]) begin
			led_d = wdat[PLCR_LED_W-1:0]; // R1
		end
		if (wr_go && idx == PLCR_IDX_PHY) begin
			if (wlane[1]) begin
				autox_d = wdat[PLCR_PHY_AUTOX];
				forcex_d = wdat[PLCR_PHY_FORCEX]; // R7
				inj_d = wdat[PLCR_PHY_INJ]; // R10
				long_d = wdat[PLCR_PHY_LONG]; // R13
				run_d = wdat[PLCR_PHY_RUN]; // R11
			end
			if (wlane[0]) begin
				byp_d = wdat[PLCR_PHY_BYP]; // R12
				mode_d = wdat[PLCR_PHY_MODE_LSB+:2]; // R14
				addr_d = wdat[PLCR_PHY_ADDR_LSB+:5];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			led_q <= PLCR_LED_RST;
			autox_q <= 1'b0;
			forcex_q <= 1'b0;
			inj_q <= 1'b0;
			long_q <= 1'b0;
			run_q <= 1'b0;
			byp_q <= 1'b0;
			mode_q <= PLCR_MODE_RST;
			addr_q <= PLCR_ADDR_RST;
			strap_q <= 1'b1;
		end else begin
			led_q <= led_d;
			autox_q <= autox_d;
			forcex_q <= forcex_d;
			inj_q <= inj_d;
			long_q <= long_d;
			run_q <= run_d;
			byp_q <= byp_d;
			mode_q <= mode_d;
			addr_q <= addr_d;
			strap_q <= strap_d;
		end
	end

	// ==========================================
	// Pause resolution and self-test status
	always_comb begin
		prx_d = full_duplex_i && local_pause_i[PLCR_PAUSE_SYM] && (partner_pause_i[PLCR_PAUSE_SYM] ||
			(local_pause_i[PLCR_PAUSE_ASM] && partner_pause_i[PLCR_PAUSE_ASM])); // R8
		ptx_d = full_duplex_i && partner_pause_i[PLCR_PAUSE_SYM] && (local_pause_i[PLCR_PAUSE_SYM] ||
			(local_pause_i[PLCR_PAUSE_ASM] && partner_pause_i[PLCR_PAUSE_ASM])); // R9
		pass_d = pass_q;
		if (run_d && !run_q) begin
			pass_d = 1'b1;
		end else if (run_q && selftest_error_i) begin
			pass_d = 1'b0; // R11
		end
		if (!run_d) begin
			pass_d = 1'b0; // R11
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			prx_q <= 1'b0;
			ptx_q <= 1'b0;
			pass_q <= 1'b0;
		end else begin
			prx_q <= prx_d;
			ptx_q <= ptx_d;
			pass_q <= pass_d;
		end
	end

	// ==========================================
	// Interrupts: sticky status, write one to clear, set wins
	always_comb begin
		iev = '0;
		iev[PLCR_IRQ_FAIL] = run_q && pass_q && selftest_error_i;
		iev[PLCR_IRQ_PAUSE] = (prx_d != prx_q) || (ptx_d != ptx_q);
		ists_d = ists_q;
		imsk_d = imsk_q;
		if (wr_go && wlane[0] && idx == PLCR_IDX_IRQ_STAT) begin
			ists_d = ists_q & ~wdat[PLCR_IRQ_W-1:0];
		end
		if (wr_go && wlane[0] && idx == PLCR_IDX_IRQ_MASK) begin
			imsk_d = wdat[PLCR_IRQ_W-1:0];
		end
		ists_d = ists_d | iev;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ists_q <= PLCR_IRQ_RST;
			imsk_q <= PLCR_IRQ_RST;
		end else begin
			ists_q <= ists_d;
			imsk_q <= imsk_d;
		end
	end

	assign irq_o = |(ists_q & imsk_q);

	// ==========================================
	// Outputs
	assign auto_crossover_enable_o = autox_q;
	assign forced_crossover_o = forcex_q; // R7
	assign port_management_address_o = addr_q;
	assign selftest_run_o = run_q; // R11
	assign selftest_long_sequence_sel_o = long_q; // R13
	assign selftest_inject_error_o = inj_q; // R10

	plcr_lamp_mux u_lamp (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.lamp_ctrl_i(led_q),
		.lamp_mode_select_i(mode_q),
		.lamp_stretch_bypass_i(byp_q),
		.link_good_i(link_good_i),
		.speed100_i(speed100_i),
		.full_duplex_i(full_duplex_i),
		.blink_i(blink_i),
		.activity_raw_i(activity_raw_i),
		.activity_stretched_i(activity_stretched_i),
		.collision_raw_i(collision_raw_i),
		.collision_stretched_i(collision_stretched_i),
		.lamp_o(lamps)
	);
	assign speed_lamp_out_o = lamps[2];
	assign link_lamp_out_o = lamps[1];
	assign activity_collision_lamp_out_o = lamps[0];

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_led_reserved_zero: assert property (st_q == PLCR_ST_ACK && idx == PLCR_IDX_LED // R1
		|-> avs_readdata_o[31:PLCR_LED_W] == '0)
		else $error("reserved override bits not zero");
	a_led_readback: assert property (st_q == PLCR_ST_ACK && avs_read_i && idx == PLCR_IDX_LED // R5
		|-> avs_readdata_o[PLCR_LED_W-1:0] == $past(led_q))
		else $error("override readback not stored value");
	a_forcex_write: assert property (wr_go && idx == PLCR_IDX_PHY && wlane[1] // R7
		|=> forced_crossover_o == $past(wdat[PLCR_PHY_FORCEX]))
		else $error("forced crossover not taken");
	a_pause_rx_half: assert property (!full_duplex_i |=> !prx_q) // R8
		else $error("pause receive set in half duplex");
	a_pause_tx_both: assert property (full_duplex_i && local_pause_i == 2'h1 && partner_pause_i == 2'h1 // R9
		|=> ptx_q && prx_q)
		else $error("symmetric pause not resolved");
	a_inject_pulse: assert property (selftest_inject_error_o |=> !selftest_inject_error_o) // R10
		else $error("inject longer than one cycle");
	a_pass_cleared: assert property ($fell(selftest_run_o) |-> !pass_q) // R11
		else $error("pass not cleared on stop");
	a_long_select: assert property (wr_go && idx == PLCR_IDX_PHY && wlane[1] // R13
		|=> selftest_long_sequence_sel_o == $past(wdat[PLCR_PHY_LONG]))
		else $error("sequence select not taken");
	a_wait_once: assert property ($rose(avs_read_i) && st_q == PLCR_ST_IDLE |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("read not answered after one wait");

	c_read_ack: cover property (avs_read_i && !avs_waitrequest_o);
	c_write_ack: cover property (wr_go && idx == PLCR_IDX_PHY);
	c_irq_rise: cover property ($rose(irq_o));
	c_selftest_fail: cover property (run_q ##1 !pass_q && run_q);
endmodule : plcr_regs
`default_nettype wire

/* verilog/plcr_pkg.sv */
`default_nettype none
package plcr_pkg;
	// ==========================================
	// Register indices (byte address = 4 * index)
	localparam logic [5:0] PLCR_IDX_LED = 6'h18;
	localparam logic [5:0] PLCR_IDX_PHY = 6'h19;
	localparam logic [5:0] PLCR_IDX_IRQ_STAT = 6'h1c;
	localparam logic [5:0] PLCR_IDX_IRQ_MASK = 6'h1d;
	// ==========================================
	// LED override register fields
	localparam int PLCR_LED_VAL_LSB = 0;
	localparam int PLCR_LED_OVR_LSB = 3;
	localparam int PLCR_LED_W = 6;
	localparam logic [5:0] PLCR_LED_RST = 6'h00;
	// ==========================================
	// Misc control register fields
	localparam int PLCR_PHY_AUTOX = 15;
	localparam int PLCR_PHY_FORCEX = 14;
	localparam int PLCR_PHY_PRX = 13;
	localparam int PLCR_PHY_PTX = 12;
	localparam int PLCR_PHY_INJ = 11;
	localparam int PLCR_PHY_LONG = 10;
	localparam int PLCR_PHY_PASS = 9;
	localparam int PLCR_PHY_RUN = 8;
	localparam int PLCR_PHY_BYP = 7;
	localparam int PLCR_PHY_MODE_LSB = 5;
	localparam int PLCR_PHY_ADDR_LSB = 0;
	localparam logic [1:0] PLCR_MODE_RST = 2'h0;
	localparam logic [4:0] PLCR_ADDR_RST = 5'h00;
	// ==========================================
	// Interrupt bits
	localparam int PLCR_IRQ_W = 2;
	localparam int PLCR_IRQ_FAIL = 0;
	localparam int PLCR_IRQ_PAUSE = 1;
	localparam logic [1:0] PLCR_IRQ_RST = 2'h0;
	// ==========================================
	// Pause advertisement bit order: [1] asymmetric, [0] symmetric
	localparam int PLCR_PAUSE_SYM = 0;
	localparam int PLCR_PAUSE_ASM = 1;

	typedef enum logic [0:0] {
		PLCR_ST_IDLE = 1'b0,
		PLCR_ST_ACK = 1'b1
	} plcr_bus_e;
endpackage : plcr_pkg
`default_nettype wire

/* verilog/plcr_lamp_mux.sv */
`default_nettype none
module plcr_lamp_mux import plcr_pkg::*; (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Configuration
	input wire logic [PLCR_LED_W-1:0] lamp_ctrl_i,
	input wire logic [1:0] lamp_mode_select_i,
	input wire logic lamp_stretch_bypass_i,
	// Line state
	input wire logic link_good_i,
	input wire logic speed100_i,
	input wire logic full_duplex_i,
	input wire logic blink_i,
	input wire logic activity_raw_i,
	input wire logic activity_stretched_i,
	input wire logic collision_raw_i,
	input wire logic collision_stretched_i,
	// Lamps, index 0 activity/collision, 1 link, 2 speed
	output logic [2:0] lamp_o
);
	logic act;
	logic col;
	logic [2:0] norm;
	logic [2:0] lamp_d;
	logic [2:0] lamp_q;

	// ==========================================
	// Normal function
	always_comb begin
		act = lamp_stretch_bypass_i ? activity_raw_i : activity_stretched_i; // R12
		col = lamp_stretch_bypass_i ? collision_raw_i : collision_stretched_i; // R12
		norm[2] = speed100_i; // R14
		if (lamp_mode_select_i[0]) begin
			norm[1] = link_good_i; // R14
			norm[0] = act;
		end else begin
			norm[1] = link_good_i & ~(act & blink_i); // R14
			norm[0] = lamp_mode_select_i[1] ? full_duplex_i : col; // R14
		end
	end

	// ==========================================
	// Software override per lamp
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ovr
			assign lamp_d[gi] = lamp_ctrl_i[PLCR_LED_OVR_LSB+gi] ? lamp_ctrl_i[PLCR_LED_VAL_LSB+gi] : norm[gi]; // R2 R3 R4
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			lamp_q <= 3'h0;
		end else begin
			lamp_q <= lamp_d;
		end
	end
	assign lamp_o = lamp_q;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_speed_forced: assert property (lamp_ctrl_i[5] |=> lamp_o[2] == $past(lamp_ctrl_i[2])) // R2
		else $error("speed lamp not forced");
	a_link_forced: assert property (lamp_ctrl_i[4] |=> lamp_o[1] == $past(lamp_ctrl_i[1])) // R3
		else $error("link lamp not forced");
	a_act_forced: assert property (lamp_ctrl_i[3] |=> lamp_o[0] == $past(lamp_ctrl_i[0])) // R4
		else $error("activity lamp not forced");
	a_stretch_bypass: assert property (!lamp_ctrl_i[3] && lamp_mode_select_i[0] && lamp_stretch_bypass_i // R12
		|=> lamp_o[0] == $past(activity_raw_i))
		else $error("bypass does not show raw activity");
	a_speed_normal: assert property (!lamp_ctrl_i[5] |=> lamp_o[2] == $past(speed100_i)) // R14
		else $error("speed lamp not following rate");
	c_link_blink: cover property (!lamp_ctrl_i[4] && !lamp_mode_select_i[0] && link_good_i && act && blink_i);
endmodule : plcr_lamp_mux
`default_nettype wire

/* verif/plcr_regs_tb_top.sv */
`default_nettype none
module plcr_regs_tb_top import plcr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Design signals
	logic clk_sys_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
	logic [7:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rdata;
	logic [3:0] avs_byteenable_i;
	logic strap_auto_crossover_i, strap_lamp_mode0_i, full_duplex_i, selftest_error_i;
	logic [4:0] strap_port_addr_i, port_management_address_o;
	logic [1:0] local_pause_i, partner_pause_i;
	logic selftest_run_o, selftest_long_sequence_sel_o, selftest_inject_error_o;
	logic auto_crossover_enable_o, forced_crossover_o;
	logic link_good_i, speed100_i, blink_i, activity_raw_i, activity_stretched_i, collision_raw_i, collision_stretched_i;
	logic speed_lamp_out_o, link_lamp_out_o, activity_collision_lamp_out_o;
	int failures, samples_checked, inj_cnt;

	plcr_regs u_dut (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .strap_auto_crossover_i, .strap_lamp_mode0_i,
		.strap_port_addr_i, .local_pause_i, .partner_pause_i, .full_duplex_i, .selftest_error_i, .selftest_run_o,
		.selftest_long_sequence_sel_o, .selftest_inject_error_o, .auto_crossover_enable_o, .forced_crossover_o,
		.port_management_address_o, .link_good_i, .speed100_i, .blink_i, .activity_raw_i, .activity_stretched_i,
		.collision_raw_i, .collision_stretched_i, .speed_lamp_out_o, .link_lamp_out_o,
		.activity_collision_lamp_out_o, .irq_o);

	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i) if (selftest_inject_error_o === 1'b1) inj_cnt++;

	// ==========================================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
		@(posedge clk_sys_i);
		avs_address_i <= {idx, 2'b00};
		avs_read_i <= ~wr;
		avs_write_i <= wr;
		avs_writedata_i <= {16'h0000, wd};
		// Wait for the answer; only the watchdog ends a stuck wait
		do begin
			@(posedge clk_sys_i);
		end while (avs_waitrequest_o !== 1'b0);
		rdata = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus

	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		bus(1'b1, idx, d);
	endtask : wr

	task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 16'h0000);
		chk(rdata, exp);
	endtask : rdchk

	task automatic lampchk(input logic [2:0] exp);
		repeat (3) @(posedge clk_sys_i);
		chk({29'h0, speed_lamp_out_o, link_lamp_out_o, activity_collision_lamp_out_o}, {29'h0, exp});
	endtask : lampchk

	task automatic lampcase(input logic [15:0] d, input logic [2:0] exp);
		wr(PLCR_IDX_PHY, d);
		lampchk(exp);
	endtask : lampcase

	// ==========================================
	// Scenarios
	task automatic t_reset;
		rdchk(PLCR_IDX_LED, 32'h0);
		rdchk(PLCR_IDX_PHY, 32'h8035);
		chk({31'h0, auto_crossover_enable_o}, 32'h1);
		chk({27'h0, port_management_address_o}, 32'h15);
		$display("test reset done");
	endtask : t_reset

	task automatic t_led;
		wr(PLCR_IDX_LED, 16'hffff);
		rdchk(PLCR_IDX_LED, 32'h3f);
		lampchk(3'b111);
		avs_byteenable_i <= 4'h2;
		wr(PLCR_IDX_LED, 16'hff00);
		avs_byteenable_i <= 4'hf;
		rdchk(PLCR_IDX_LED, 32'h3f);
		wr(PLCR_IDX_LED, 16'h0007);
		lampchk(3'b000);
		rdchk(PLCR_IDX_LED, 32'h7);
		for (int i = 0; i < 3; i++) begin
			wr(PLCR_IDX_LED, (16'h0008 << i) | (16'h0001 << i));
			lampchk(3'b001 << i);
		end
		// Sources say on, overrides force off
		speed100_i <= 1'b1;
		link_good_i <= 1'b1;
		activity_stretched_i <= 1'b1;
		wr(PLCR_IDX_LED, 16'h0038);
		lampchk(3'b000);
		rdchk(PLCR_IDX_LED, 32'h38);
		wr(PLCR_IDX_LED, 16'h0000);
		lampchk(3'b111);
		$display("test led override done");
	endtask : t_led

	task automatic t_cross;
		wr(PLCR_IDX_PHY, 16'h4020);
		rdchk(PLCR_IDX_PHY, 32'h4020);
		chk({30'h0, auto_crossover_enable_o, forced_crossover_o}, 32'h1);
		wr(PLCR_IDX_PHY, 16'h8020);
		@(posedge clk_sys_i);
		chk({30'h0, auto_crossover_enable_o, forced_crossover_o}, 32'h2);
		$display("test crossover done");
	endtask : t_cross

	task automatic t_selftest;
		int n;
		wr(PLCR_IDX_PHY, 16'h0500);
		@(posedge clk_sys_i);
		chk({30'h0, selftest_run_o, selftest_long_sequence_sel_o}, 32'h3);
		rdchk(PLCR_IDX_PHY, 32'h0700);
		selftest_error_i <= 1'b1;
		@(posedge clk_sys_i);
		selftest_error_i <= 1'b0;
		rdchk(PLCR_IDX_PHY, 32'h0500);
		wr(PLCR_IDX_PHY, 16'h0100);
		rdchk(PLCR_IDX_PHY, 32'h0100);
		chk({31'h0, selftest_long_sequence_sel_o}, 32'h0);
		wr(PLCR_IDX_PHY, 16'h0000);
		rdchk(PLCR_IDX_PHY, 32'h0);
		wr(PLCR_IDX_PHY, 16'h0100);
		rdchk(PLCR_IDX_PHY, 32'h0300);
		wr(PLCR_IDX_PHY, 16'h0000);
		n = inj_cnt;
		wr(PLCR_IDX_PHY, 16'h0800);
		repeat (4) @(posedge clk_sys_i);
		chk(32'(inj_cnt - n), 32'h1);
		rdchk(PLCR_IDX_PHY, 32'h0);
		$display("test self-test done");
	endtask : t_selftest

	task automatic t_irq;
		rdchk(PLCR_IDX_IRQ_STAT, 32'h1);
		chk({31'h0, irq_o}, 32'h0);
		wr(PLCR_IDX_IRQ_MASK, 16'h0001);
		@(posedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h1);
		wr(PLCR_IDX_IRQ_STAT, 16'h0001);
		@(posedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h0);
		rdchk(PLCR_IDX_IRQ_STAT, 32'h0);
		wr(6'h3f, 16'hffff);
		rdchk(6'h3f, 32'h0);
		wr(PLCR_IDX_IRQ_MASK, 16'h0002);
		$display("test interrupt done");
	endtask : t_irq

	task automatic t_pause;
		logic rx, tx;
		for (int c = 0; c < 32; c++) begin
			local_pause_i <= c[1:0];
			partner_pause_i <= c[3:2];
			full_duplex_i <= c[4];
			rx = c[4] & c[0] & (c[2] | (c[1] & c[3]));
			tx = c[4] & c[2] & (c[0] | (c[1] & c[3]));
			repeat (2) @(posedge clk_sys_i);
			bus(1'b0, PLCR_IDX_PHY, 16'h0000);
			chk({30'h0, rdata[13:12]}, {30'h0, rx, tx});
		end
		chk({31'h0, irq_o}, 32'h1);
		wr(PLCR_IDX_IRQ_STAT, 16'h0002);
		@(posedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h0);
		$display("test pause done");
	endtask : t_pause

	task automatic t_lamp;
		speed100_i <= 1'b1;
		link_good_i <= 1'b1;
		blink_i <= 1'b1;
		activity_raw_i <= 1'b1;
		activity_stretched_i <= 1'b0;
		collision_raw_i <= 1'b0;
		collision_stretched_i <= 1'b1;
		full_duplex_i <= 1'b1;
		lampcase(16'h0020, 3'b110);
		lampcase(16'h0060, 3'b110);
		lampcase(16'h00a0, 3'b111);
		lampcase(16'h0000, 3'b111);
		lampcase(16'h0080, 3'b100);
		lampcase(16'h0040, 3'b111);
		full_duplex_i <= 1'b0;
		speed100_i <= 1'b0;
		lampchk(3'b010);
		$display("test lamp modes done");
	endtask : t_lamp

	task automatic results;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	// ==========================================
	// Main sequence and watchdog
	initial begin
		rst_i = 1'b1;
		{avs_address_i, avs_writedata_i, avs_byteenable_i} = {8'h00, 32'h0, 4'hf};
		{avs_read_i, avs_write_i, selftest_error_i, full_duplex_i} = 4'h0;
		{strap_auto_crossover_i, strap_lamp_mode0_i, strap_port_addr_i} = 7'h75;
		{local_pause_i, partner_pause_i} = 4'h0;
		{link_good_i, speed100_i, blink_i, activity_raw_i} = 4'h0;
		{activity_stretched_i, collision_raw_i, collision_stretched_i} = 3'h0;
		repeat (12) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		t_reset;
		t_led;
		t_cross;
		t_selftest;
		t_irq;
		t_pause;
		t_lamp;
		results;
	end

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		failures++;
		results;
	end
endmodule : plcr_regs_tb_top
`default_nettype wire
